// ### rtl/flash_fastboot_and_erase.sv
`timescale 1ns/1ps
`default_nettype none
module flash_fastboot_and_erase #(
   parameter logic [31:0] BOOT_CFG_INIT = flash_fastboot_pkg::BOOT_CFG_RESET
) (
   // core clock and power-on reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   input wire logic hw_reset_n,
   // configuration levels
   input wire logic quad_enable_bit,
   input wire logic quad_command_mode,
   input wire logic four_byte_mode,
   input wire logic extended_address_bit,
   input wire logic protection_select,
   input wire logic [3:0] block_protect_bits,
   input wire logic [flash_fastboot_pkg::PROT_BLOCKS-1:0] solid_protect_bits,
   input wire logic [flash_fastboot_pkg::PROT_BLOCKS-1:0] dynamic_protect_bits,
   // array read port, link clock
   output logic [31:0] array_read_addr,
   input wire logic [7:0] array_read_data,
   // array erase port, core clock
   output logic array_erase_pulse,
   output logic [31:0] array_erase_base,
   output logic array_erase_half_block,
   // status
   output logic write_in_progress_flag,
   output logic write_enable_latch,
   output logic boot_armed
);
   import flash_fastboot_pkg::*;

   localparam int CFG_SYNC_W = 7 + 2 * PROT_BLOCKS;

   // core-side state
   exec_state_t state_q;
   boot_cfg_t cfg_q;
   logic [31:0] cfg_pend_q;
   logic busy_q, latch_q, armed_q, cs_prev_q;
   logic erase_pulse_q, erase_half_q;
   logic [31:0] erase_base_q;
   logic cs_s, hw_reset_n_s;
   logic four_s, ext_s, psel_s;
   logic [3:0] bprot_s;
   logic [PROT_BLOCKS-1:0] solid_s, dyn_s;
   logic frame_end, soft_reset, timer_load, timer_done;
   logic [TIMER_W-1:0] timer_count;
   logic [31:0] full_addr;
   logic [10:0] blk;
   logic prot_hit, len_ok;
   exec_state_t next_busy;

   // link-side state
   frame_t link_frame;
   logic fresh_q, quad_cmd_l, quad_en_l, four_l, boot_l;
   logic [6:0] bits_q, bits_d, step;
   logic [7:0] edges_q, op_q, delay_edges, op_edges;
   logic [31:0] shift_q, shift_d, rd_addr_q;
   logic active_q, wide, start_now, last_ph, load_now;
   logic [2:0] ph_q;
   logic [1:0] byte_idx_q;
   logic [7:0] tx_q, out_byte;
   logic [3:0] io_out_q, io_oe_q;

   assign io_out = io_out_q;
   assign io_oe = io_oe_q;
   assign array_read_addr = rd_addr_q;
   assign array_erase_pulse = erase_pulse_q;
   assign array_erase_base = erase_base_q;
   assign array_erase_half_block = erase_half_q;
   assign write_in_progress_flag = busy_q;
   assign write_enable_latch = latch_q;
   assign boot_armed = armed_q;

   // ---------------- link clock domain ----------------
   // config levels only settle after two clocks of a frame
   bit_sync #(.W(3)) link_cfg_sync (
      .clk(sclk),
      .clr(1'b0),
      .d({quad_command_mode, quad_enable_bit, four_byte_mode}),
      .q({quad_cmd_l, quad_en_l, four_l})
   );

   // cleared by every deselect, valid from the second edge
   bit_sync #(.W(1)) link_arm_sync (
      .clk(sclk),
      .clr(cs_n),
      .d(armed_q),
      .q(boot_l)
   );

   // clock stops between frames, so deselect marks the next first edge
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   assign step = quad_cmd_l ? 7'h04 : 7'h01;

   always_comb begin
      if (fresh_q) begin
         bits_d = step;
         shift_d = quad_cmd_l ? {28'h0000000, io_in} : {31'h00000000, io_in[0]};
      end else begin
         bits_d = (bits_q > BIT_COUNT_SAT) ? bits_q : bits_q + step;
         // upper lines ignored in single mode
         shift_d = quad_cmd_l ? {shift_q[27:0], io_in} : {shift_q[30:0], io_in[0]};
      end
   end

   // frame capture stays put after deselect for the core to read
   always_ff @(posedge sclk) begin
      bits_q <= bits_d;
      shift_q <= shift_d;
      if (fresh_q) begin
         edges_q <= 8'h01;
      end else if (edges_q != 8'hff) begin
         edges_q <= edges_q + 8'h01;
      end
      if (bits_d == OP_ONLY_BITS) begin
         op_q <= shift_d[7:0];
      end
   end

   assign link_frame = '{opcode: op_q, payload: shift_q, bit_count: bits_q};

   // delay 7 + 2 * code
   assign delay_edges = BOOT_DELAY_BASE + {5'h00, cfg_q.boot_delay_code, 1'b0};
   assign op_edges = quad_cmd_l ? OP_EDGES_QUAD : OP_EDGES_SINGLE;
   assign wide = boot_l ? quad_en_l : quad_cmd_l;
   assign start_now = !active_q && (boot_l ? (edges_q == delay_edges)
                                           : (edges_q == op_edges && op_q == OP_READ_BOOT_CFG));
   assign last_ph = ph_q == (wide ? 3'h1 : 3'h7);
   assign load_now = !fresh_q && (start_now || (active_q && last_ph));
   assign out_byte = boot_l ? array_read_data : cfg_q[{byte_idx_q, 3'b000} +: 8];

   // deselect releases the lines at once
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         active_q <= 1'b0;
         ph_q <= 3'h0;
         byte_idx_q <= 2'h0;
         tx_q <= 8'h00;
         io_out_q <= 4'h0;
         io_oe_q <= 4'h0;
      end else if (load_now) begin
         active_q <= 1'b1;
         ph_q <= 3'h0;
         byte_idx_q <= byte_idx_q + 2'h1;
         tx_q <= wide ? {out_byte[3:0], 4'h0} : {out_byte[6:0], 1'b0};
         // single data on line 1, quad on all
         io_out_q <= wide ? out_byte[7:4] : {2'b00, out_byte[7], 1'b0};
         io_oe_q <= wide ? 4'hf : 4'h2;
      end else if (active_q) begin
         ph_q <= ph_q + 3'h1;
         tx_q <= wide ? {tx_q[3:0], 4'h0} : {tx_q[6:0], 1'b0};
         io_out_q <= wide ? tx_q[7:4] : {2'b00, tx_q[7], 1'b0};
      end
   end

   // start address aligned to 16 bytes
   always_ff @(negedge sclk) begin
      if (!fresh_q && boot_l && edges_q == BOOT_ADDR_LOAD_EDGE) begin
         rd_addr_q <= {cfg_q.boot_start_address, 4'h0};
      end else if (boot_l && load_now) begin
         rd_addr_q <= rd_addr_q + 32'h00000001;
      end
   end

   // ---------------- core clock domain ----------------
   bit_sync #(.W(2)) core_pin_sync (
      .clk(sys_clk),
      .clr(1'b0),
      .d({cs_n, hw_reset_n}),
      .q({cs_s, hw_reset_n_s})
   );

   bit_sync #(.W(CFG_SYNC_W)) core_cfg_sync (
      .clk(sys_clk),
      .clr(1'b0),
      .d({four_byte_mode, extended_address_bit, protection_select, block_protect_bits,
          solid_protect_bits, dynamic_protect_bits}),
      .q({four_s, ext_s, psel_s, bprot_s, solid_s, dyn_s})
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_s;
      end
   end

   // work starts on the select rise
   assign frame_end = cs_s && !cs_prev_q;

   // three-byte address takes the extension bit on top
   assign full_addr = four_s ? link_frame.payload
                             : {7'h00, ext_s, link_frame.payload[23:0]};
   assign blk = full_addr[PROT_BLOCK_LSB +: 11];

   // protect by block bits or per-block bits
   always_comb begin
      if (psel_s) begin
         prot_hit = solid_s[blk] || dyn_s[blk];
      end else if (bprot_s == 4'h0) begin
         prot_hit = 1'b0;
      end else begin
         prot_hit = int'(blk) >= PROT_BLOCKS - (1 << (int'(bprot_s) - 1));
      end
   end

   // select must rise right after the last address bit
   assign len_ok = link_frame.bit_count == (four_s ? ERASE_BITS_4B : ERASE_BITS_3B);

   assign soft_reset = state_q == ST_IDLE && frame_end && !armed_q
                       && link_frame.opcode == OP_RESET_DEVICE && link_frame.bit_count == OP_ONLY_BITS;

   // what a finished frame starts, if anything
   always_comb begin
      next_busy = ST_IDLE;
      timer_count = SMALL_ERASE_CYCLES;
      if (state_q == ST_IDLE && frame_end && !armed_q && latch_q) begin
         if (link_frame.opcode == OP_SMALL_ERASE && len_ok && !prot_hit) begin
            next_busy = ST_ERASE;
         end else if (link_frame.opcode == OP_HALF_BLOCK_ERASE && len_ok && !prot_hit) begin
            next_busy = ST_ERASE;
            timer_count = HALF_BLOCK_ERASE_CYCLES;
         end else if (link_frame.opcode == OP_PROGRAM_BOOT_CFG && link_frame.bit_count == CFG_PROG_BITS) begin
            next_busy = ST_CFG_PROG;
            timer_count = CFG_PROG_CYCLES;
         end else if (link_frame.opcode == OP_ERASE_BOOT_CFG && link_frame.bit_count == OP_ONLY_BITS) begin
            next_busy = ST_CFG_ERASE;
            timer_count = CFG_ERASE_CYCLES;
         end
      end
   end

   assign timer_load = next_busy != ST_IDLE;

   busy_timer op_timer (
      .clk(sys_clk),
      .rst(rst),
      .load(timer_load),
      .count(timer_count),
      .done(timer_done)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         busy_q <= 1'b0;
         cfg_pend_q <= 32'h00000000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (timer_load) begin
                  state_q <= next_busy;
                  // busy for the whole timed operation
                  busy_q <= 1'b1;
                  cfg_pend_q <= link_frame.payload;
               end
            end
            default: begin
               if (timer_done) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // write enable latch gates every change
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         latch_q <= 1'b0;
      end else if (state_q != ST_IDLE && timer_done) begin
         latch_q <= 1'b0;
      end else if (!hw_reset_n_s || soft_reset) begin
         latch_q <= 1'b0;
      end else if (state_q == ST_IDLE && frame_end && !armed_q
                   && link_frame.opcode == OP_WRITE_ENABLE && link_frame.bit_count == OP_ONLY_BITS) begin
         latch_q <= 1'b1;
      end
   end

   // sector and half block base addresses
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         erase_pulse_q <= 1'b0;
         erase_half_q <= 1'b0;
         erase_base_q <= 32'h00000000;
      end else begin
         erase_pulse_q <= next_busy == ST_ERASE;
         if (next_busy == ST_ERASE) begin
            erase_half_q <= link_frame.opcode == OP_HALF_BLOCK_ERASE;
            if (link_frame.opcode == OP_HALF_BLOCK_ERASE) begin
               erase_base_q <= {full_addr[31:HALF_BLOCK_LSB], 15'h0000};
            end else begin
               erase_base_q <= {full_addr[31:SECTOR_LSB], 12'h000};
            end
         end
      end
   end

   // nonvolatile image, reloaded only by power-on
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q <= BOOT_CFG_INIT;
      end else if (timer_done && state_q == ST_CFG_PROG) begin
         cfg_q <= cfg_q & cfg_pend_q;
      end else if (timer_done && state_q == ST_CFG_ERASE) begin
         cfg_q <= BOOT_CFG_RESET;
      end
   end

   // re-arm on every reset kind, disarm on first frame end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         armed_q <= !BOOT_CFG_INIT[0];
      end else if (!hw_reset_n_s || soft_reset) begin
         armed_q <= !cfg_q.boot_read_disable_n;
      end else if (frame_end) begin
         armed_q <= 1'b0;
      end
   end
endmodule // flash_fastboot_and_erase
`default_nettype wire

// ### inc/flash_fastboot_pkg.sv
// Summary of operation
// - boot read starts alone after any reset
// - first frame streams from start after delay
// - default delay 13, start 16-byte aligned
// - chip select rise returns to commands
// - boot data one line, four if quad
// - start address bits 31:4, default ones
// - bit 0 low enables boot read
// - program, erase, read boot configuration
// - sector erase needs write enable latch
// - erase needs select rise on boundary
// - sector picked by address bits 12 up
// - half block picked by bits 15 up
// - opcode eight single or two quad clocks
// - erase starts at rise, busy flag
// - protected targets are never erased
`default_nettype none
package flash_fastboot_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_SMALL_ERASE = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
   localparam logic [7:0] OP_PROGRAM_BOOT_CFG = 8'h17;
   localparam logic [7:0] OP_ERASE_BOOT_CFG = 8'h18;
   localparam logic [7:0] OP_READ_BOOT_CFG = 8'h16;
   localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
   localparam logic [31:0] BOOT_CFG_RESET = 32'hffff_ffff;
   localparam logic [7:0] BOOT_DELAY_BASE = 8'h07;
   localparam logic [7:0] BOOT_ADDR_LOAD_EDGE = 8'h02;
   localparam logic [7:0] OP_EDGES_SINGLE = 8'h08;
   localparam logic [7:0] OP_EDGES_QUAD = 8'h02;
   localparam logic [6:0] OP_ONLY_BITS = 7'h08;
   localparam logic [6:0] ERASE_BITS_3B = 7'h20;
   localparam logic [6:0] ERASE_BITS_4B = 7'h28;
   localparam logic [6:0] CFG_PROG_BITS = 7'h28;
   localparam logic [6:0] BIT_COUNT_SAT = 7'h78;
   localparam int SECTOR_LSB = 12;
   localparam int HALF_BLOCK_LSB = 15;
   localparam int PROT_BLOCK_LSB = 16;
   localparam int PROT_BLOCKS = 2048;
   localparam int TIMER_W = 12;
   localparam int SMALL_ERASE_TIME_NS = 30000;
   localparam int HALF_BLOCK_ERASE_TIME_NS = 150000;
   localparam int CFG_PROG_TIME_NS = 20000;
   localparam int CFG_ERASE_TIME_NS = 30000;
   localparam logic [TIMER_W-1:0] SMALL_ERASE_CYCLES = TIMER_W'(SMALL_ERASE_TIME_NS / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] HALF_BLOCK_ERASE_CYCLES = TIMER_W'(HALF_BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] CFG_PROG_CYCLES = TIMER_W'(CFG_PROG_TIME_NS / CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] CFG_ERASE_CYCLES = TIMER_W'(CFG_ERASE_TIME_NS / CLK_PERIOD_NS);

   typedef struct packed {
      logic [27:0] boot_start_address;
      logic unused;
      logic [1:0] boot_delay_code;
      logic boot_read_disable_n;
   } boot_cfg_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [31:0] payload;
      logic [6:0] bit_count;
   } frame_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ERASE = 4'b0010,
      ST_CFG_PROG = 4'b0100,
      ST_CFG_ERASE = 4'b1000
   } exec_state_t;
endpackage
`default_nettype wire

// ### rtl/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int W = 1
) (
   // clock and asynchronous clear to zero
   input wire logic clk,
   input wire logic clr,
   // level in and synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge clr) begin
      if (clr) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // bit_sync
`default_nettype wire

// ### rtl/busy_timer.sv
`timescale 1ns/1ps
`default_nettype none
module busy_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // start with a cycle count, pulse when it runs out
   input wire logic load,
   input wire logic [flash_fastboot_pkg::TIMER_W-1:0] count,
   output logic done
);
   import flash_fastboot_pkg::*;
   logic [TIMER_W-1:0] cnt_q;
   logic run_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_q <= count;
            run_q <= 1'b1;
         end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 1) begin
               run_q <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule // busy_timer
`default_nettype wire

// ### dv/flash_fastboot_sva.sv
`timescale 1ns/1ps
`default_nettype none
module flash_fastboot_sva #(
   parameter logic [31:0] BOOT_CFG_INIT = 32'hffff_ffff
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // link and status
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   input wire logic boot_armed,
   input wire logic array_erase_pulse,
   input wire logic [31:0] array_erase_base,
   input wire logic array_erase_half_block,
   input wire logic write_in_progress_flag,
   input wire logic write_enable_latch
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_ready;
      // pulse and busy rise together, so look at the cycle before
      $past(!write_in_progress_flag && write_enable_latch);
   endsequence
   sequence s_busy;
      write_in_progress_flag [*8];
   endsequence
   AST_ERASE_GATED: assert property (array_erase_pulse |-> s_ready)
      else $error("erase started without latch or while busy");
   AST_ERASE_BUSY: assert property (array_erase_pulse |=> s_busy)
      else $error("busy flag not held after erase start");
   AST_PULSE_SINGLE: assert property (array_erase_pulse |=> !array_erase_pulse)
      else $error("erase start longer than one cycle");
   AST_SECTOR_BASE: assert property (array_erase_pulse && !array_erase_half_block |-> array_erase_base[11:0] == 12'h000)
      else $error("sector base not aligned");
   AST_HALF_BASE: assert property (array_erase_pulse && array_erase_half_block |-> array_erase_base[14:0] == 15'h0000)
      else $error("half block base not aligned");
   AST_AFTER_RISE: assert property (array_erase_pulse |-> cs_n && $past(cs_n) && $past(cs_n, 2))
      else $error("erase started before deselect");
   AST_DONE_CLEARS: assert property ($fell(write_in_progress_flag) |-> !write_enable_latch)
      else $error("latch left set after completion");
   AST_IDLE_RELEASE: assert property (cs_n && $past(cs_n) |-> io_oe == 4'h0)
      else $error("lines driven while deselected");
   AST_OE_WIDTH: assert property (|io_oe |-> io_oe == 4'h2 || io_oe == 4'hf)
      else $error("illegal line enable pattern");
   AST_ARM_RESET: assert property ($fell(rst) |-> boot_armed == !BOOT_CFG_INIT[0])
      else $error("boot arm wrong after reset");
endmodule // flash_fastboot_sva
bind flash_fastboot_and_erase flash_fastboot_sva #(.BOOT_CFG_INIT(BOOT_CFG_INIT)) u_sva (.sys_clk, .rst, .cs_n,
   .io_oe, .boot_armed, .array_erase_pulse, .array_erase_base, .array_erase_half_block, .write_in_progress_flag,
   .write_enable_latch);
`default_nettype wire

// ### dv/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   // serial link toward the device
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      io_in = 4'h5;
      // a real deselect edge clears the output stage and the arm sync, and sets the fresh flag, before any frame
      #1 cs_n = 1'b1;
   end
   task automatic frame(input logic [39:0] tx, input int nclk, input int skip, input bit q,
                        output logic [31:0] rx);
      rx = '0;
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < nclk; i++) begin
         // upper lines churn in single mode
         io_in = q ? tx[39:36] : {3'(i), tx[39]};
         tx = q ? tx << 4 : tx << 1;
         #40 sclk = 1'b1;
         if (i >= skip) rx = q ? {rx[27:0], io_out} : {rx[30:0], io_out[1]};
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      // released lines must not look like held data
      io_in = ~io_in;
      #300;
   endtask
endmodule // flash_host_model
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import flash_fastboot_pkg::*;
   typedef struct {
      logic [7:0] op;
      logic [23:0] addr;
      bit write_enable_cmd;
      bit q;
      bit [1:0] prot;
      int nclk;
      bit go;
      logic [31:0] base;
   } row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic quad_enable_bit = 1'b0;
   logic quad_command_mode = 1'b0;
   logic protection_select = 1'b0;
   logic hw_reset_n = 1'b1;
   logic [3:0] block_protect_bits = 4'h0;
   logic [PROT_BLOCKS-1:0] dynamic_protect_bits = '0;
   logic sclk, cs_n, array_erase_pulse, array_erase_half_block, write_in_progress_flag, write_enable_latch;
   logic boot_armed, got_half;
   logic [3:0] io_in, io_out, io_oe;
   logic [31:0] array_read_addr, array_erase_base, rx, got_base;
   int bad_count = 0;
   int check_count = 0;
   int pulses = 0;
   int n;
   row_t rows[7];
   always #25 sys_clk = ~sys_clk;
   flash_fastboot_and_erase #(.BOOT_CFG_INIT(32'h0000_0106)) u_dut (.sys_clk, .rst, .sclk, .cs_n, .io_in, .io_out,
      .io_oe, .hw_reset_n, .quad_enable_bit, .quad_command_mode, .four_byte_mode(1'b0),
      .extended_address_bit(1'b0), .protection_select, .block_protect_bits,
      .solid_protect_bits({PROT_BLOCKS{1'b0}}), .dynamic_protect_bits, .array_read_addr,
      .array_read_data(array_read_addr[7:0] ^ 8'h5a), .array_erase_pulse, .array_erase_base,
      .array_erase_half_block, .write_in_progress_flag, .write_enable_latch, .boot_armed);
   flash_host_model u_host (.sclk, .cs_n, .io_in, .io_out);
   always @(posedge sys_clk) begin
      if (array_erase_pulse) begin
         pulses <= pulses + 1;
         got_base <= array_erase_base;
         got_half <= array_erase_half_block;
      end
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (write_in_progress_flag !== 1'b0 && k < 4000) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 4000) begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic send(input logic [7:0] op, input logic [31:0] pl, input int nclk, input bit q);
      u_host.frame({op, pl}, nclk, 99, q, rx);
   endtask
   initial begin
      rows[0] = '{OP_SMALL_ERASE, 24'h012345, 1, 0, 0, 32, 1, 32'h0001_2000};
      rows[1] = '{OP_HALF_BLOCK_ERASE, 24'h01ffff, 1, 1, 0, 32, 1, 32'h0001_8000};
      rows[2] = '{OP_SMALL_ERASE, 24'h012345, 0, 0, 0, 32, 0, 32'h0};
      rows[3] = '{OP_SMALL_ERASE, 24'h012345, 1, 0, 1, 32, 0, 32'h0};
      rows[4] = '{OP_SMALL_ERASE, 24'h012345, 1, 0, 0, 31, 0, 32'h0};
      rows[5] = '{OP_HALF_BLOCK_ERASE, 24'h007fff, 1, 0, 0, 32, 1, 32'h0};
      // prot 2: block-protect bits cover every block
      rows[6] = '{OP_HALF_BLOCK_ERASE, 24'h012345, 1, 1, 2, 32, 0, 32'h0};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk({boot_armed, write_in_progress_flag, write_enable_latch}, 3'b100);
      u_host.frame('0, 29, 13, 0, rx);
      chk(rx[15:0], 16'h5a5b);
      chk(boot_armed, 1'b0);
      u_host.frame({OP_READ_BOOT_CFG, 32'h0}, 40, 8, 0, rx);
      chk(rx, 32'h0601_0000);
      foreach (rows[k]) begin
         @(posedge sys_clk);
         quad_command_mode <= rows[k].q;
         protection_select <= rows[k].prot[0];
         block_protect_bits <= rows[k].prot[1] ? 4'hc : 4'h0;
         dynamic_protect_bits <= {{(PROT_BLOCKS - 2){1'b0}}, rows[k].prot[0], 1'b0};
         @(posedge sys_clk);
         // short junk frame lets the mode change settle
         send(8'h00, 32'h0, 2, rows[k].q);
         if (rows[k].write_enable_cmd) begin
            send(OP_WRITE_ENABLE, 32'h0, rows[k].q ? 2 : 8, rows[k].q);
            chk(write_enable_latch, 1'b1);
         end
         n = pulses;
         send(rows[k].op, {rows[k].addr, 8'h00}, rows[k].q ? rows[k].nclk / 4 : rows[k].nclk, rows[k].q);
         chk(pulses - n, rows[k].go);
         if (rows[k].go) begin
            chk({got_half, got_base}, {rows[k].op == OP_HALF_BLOCK_ERASE, rows[k].base});
            chk(write_in_progress_flag, 1'b1);
            wait_idle();
            chk(write_enable_latch, 1'b0);
         end else chk(write_in_progress_flag, 1'b0);
      end
      @(posedge sys_clk);
      quad_command_mode <= 1'b0;
      block_protect_bits <= 4'h0;
      quad_enable_bit <= 1'b1;
      send(8'h00, 32'h0, 2, 0);
      send(OP_WRITE_ENABLE, 32'h0, 8, 0);
      send(OP_PROGRAM_BOOT_CFG, 32'hffff_fff0, 40, 0);
      wait_idle();
      u_host.frame({OP_READ_BOOT_CFG, 32'h0}, 40, 8, 0, rx);
      chk(rx, 32'h0001_0000);
      send(OP_RESET_DEVICE, 32'h0, 8, 0);
      chk(boot_armed, 1'b1);
      u_host.frame('0, 11, 7, 1, rx);
      chk(rx[15:0], 16'h5a5b);
      // mid-run hardware reset re-arms the boot read
      @(posedge sys_clk);
      hw_reset_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      hw_reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk(boot_armed, 1'b1);
      u_host.frame('0, 11, 7, 1, rx);
      chk(rx[15:0], 16'h5a5b);
      send(OP_WRITE_ENABLE, 32'h0, 8, 0);
      send(OP_ERASE_BOOT_CFG, 32'h0, 8, 0);
      wait_idle();
      u_host.frame({OP_READ_BOOT_CFG, 32'h0}, 40, 8, 0, rx);
      chk(rx, 32'hffff_ffff);
      send(OP_RESET_DEVICE, 32'h0, 8, 0);
      chk(boot_armed, 1'b0);
      test_done();
   end
endmodule // tb_top
`default_nettype wire
